// ===== core/udpe_pkg.sv
package udpe_pkg;

    // Clock and protocol timing, counter width and sizes
    localparam int UDPE_CLK_MHZ          = 100;
    localparam int UDPE_FULLSPEED_MHZ    = 48;
    localparam int UDPE_FRAME_TIME_US    = 1000;
    localparam int UDPE_IDLE_TIME_US     = 3000;
    localparam int UDPE_WAKE_TIME_US     = 10000;
    localparam int UDPE_CNT_W            = 20;
    localparam int UDPE_ISO_MAX_BYTES    = 1023;
    localparam int UDPE_EP_REGS          = 8;

    // Register byte addresses
    localparam logic [7:0] UDPE_OFS_CONTROL  = 8'h00;
    localparam logic [7:0] UDPE_OFS_CONFIG   = 8'h04;
    localparam logic [7:0] UDPE_OFS_STATUS   = 8'h08;
    localparam logic [7:0] UDPE_OFS_ADDRESS  = 8'h0C;
    localparam logic [7:0] UDPE_OFS_FRAME_LO = 8'h10;
    localparam logic [7:0] UDPE_OFS_FRAME_HI = 8'h14;
    localparam logic [7:0] UDPE_OFS_IRQ_FLAG = 8'h18;
    localparam logic [7:0] UDPE_OFS_IRQ_EN   = 8'h1C;
    localparam logic [7:0] UDPE_OFS_ERR_FLAG = 8'h20;
    localparam logic [7:0] UDPE_OFS_ERR_EN   = 8'h24;
    localparam logic [7:0] UDPE_OFS_EP0      = 8'h28;
    localparam logic [7:0] UDPE_OFS_EP_LAST  = 8'h44;

    // usb_control bits
    localparam int UDPE_CTL_ENABLE  = 3;
    localparam int UDPE_CTL_RESUME  = 2;
    localparam int UDPE_CTL_SUSPEND = 1;
    // usb_configuration bits
    localparam int UDPE_CFG_PULLUP  = 4;
    localparam int UDPE_CFG_FULLSPD = 2;
    // endpoint control bits
    localparam int UDPE_EP_HSHK     = 4;
    localparam int UDPE_EP_CONDIS   = 3;
    localparam int UDPE_EP_OUTEN    = 2;
    localparam int UDPE_EP_INEN     = 1;
    localparam int UDPE_EP_STALL    = 0;
    // link_interrupt_flags bits
    localparam int UDPE_IRQ_SOF     = 6;
    localparam int UDPE_IRQ_STALL   = 5;
    localparam int UDPE_IRQ_IDLE    = 4;
    localparam int UDPE_IRQ_TRN     = 3;
    localparam int UDPE_IRQ_ACTV    = 2;
    localparam int UDPE_IRQ_ERR     = 1;
    localparam int UDPE_IRQ_RESET   = 0;
    // transfer_status fields
    localparam int UDPE_STAT_EP_LSB = 3;
    localparam int UDPE_STAT_DIR    = 2;

    // Writable masks and reset values
    localparam logic [7:0] UDPE_CTL_WMASK   = 8'h0E;
    localparam logic [7:0] UDPE_CFG_WMASK   = 8'h14;
    localparam logic [7:0] UDPE_EP_WMASK    = 8'h1F;
    localparam logic [7:0] UDPE_IRQ_WMASK   = 8'h7F;
    localparam logic [7:0] UDPE_ERR_WMASK   = 8'h9F;
    localparam logic [7:0] UDPE_EP0_RESET   = 8'h16;
    localparam logic [6:0] UDPE_DEFAULT_ADDR = 7'h00;

    typedef enum logic [1:0] {
        UDPE_PID_OUT,
        UDPE_PID_IN,
        UDPE_PID_SOF,
        UDPE_PID_SETUP
    } udpe_pid_e;

    typedef enum logic [1:0] {
        UDPE_LS_ACTIVE,
        UDPE_LS_SUSPENDED,
        UDPE_LS_WAKING,
        UDPE_LS_RESUMING
    } udpe_link_e;

    typedef struct packed {
        logic        valid;
        udpe_pid_e   pid;
        logic [6:0]  addr;
        logic [3:0]  endp;
        logic [10:0] frame;
        logic [10:0] len;
    } udpe_token_s;

    typedef struct packed {
        logic valid;
        logic accept;
        logic handshake;
        logic stall;
        logic setup;
    } udpe_result_s;

    typedef struct packed {
        logic [7:0] flags;
    } udpe_flag_state_s;

endpackage

// ===== core/udpe_flag_bank.sv
`timescale 1ns/1ps
module udpe_flag_bank
    import udpe_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    input  wire logic [7:0] i_set,
    input  wire logic [7:0] i_clear,
    input  wire logic [7:0] i_mask,
    output logic      [7:0] o_flags,
    output logic            o_pending
);
    udpe_flag_state_s st_reg;
    udpe_flag_state_s st_next;

    // Set wins over a clear in the same cycle
    always_comb begin
        st_next       = st_reg;
        st_next.flags = (st_reg.flags & ~i_clear) | i_set;
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_flags   = st_reg.flags;
    assign o_pending = |(st_reg.flags & i_mask);

endmodule // udpe_flag_bank

// ===== core/udpe_engine.sv
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module udpe_engine
    import udpe_pkg::*;
#(
    parameter int FRAME_CYC = UDPE_FRAME_TIME_US * UDPE_CLK_MHZ,
    parameter int IDLE_CYC  = UDPE_IDLE_TIME_US * UDPE_CLK_MHZ,
    parameter int WAKE_CYC  = UDPE_WAKE_TIME_US * UDPE_CLK_MHZ
)
(
    input  wire logic         i_clock,
    input  wire logic         i_nrst,
    input  wire logic         i_psel,
    input  wire logic         i_penable,
    input  wire logic         i_pwrite,
    input  wire logic [7:0]   i_paddr,
    input  wire logic [31:0]  i_pwdata,
    output logic      [31:0]  o_prdata,
    output logic              o_pready,
    output logic              o_pslverr,
    input  wire udpe_token_s  i_token,
    input  wire logic         i_bus_reset,
    input  wire logic         i_bus_activity,
    input  wire logic         i_xfer_done,
    input  wire logic [7:0]   i_link_errors,
    input  wire logic         i_wake_request,
    output udpe_result_s      o_result,
    output logic              o_frame_tick,
    output logic              o_pullup_dp,
    output logic              o_pullup_dm,
    output logic              o_pin_detect_en,
    output logic              o_suspended,
    output logic              o_resume_drive,
    output logic              o_irq
);
    localparam logic [UDPE_CNT_W-1:0] FRAME_LAST = UDPE_CNT_W'(FRAME_CYC - 1);
    localparam logic [UDPE_CNT_W-1:0] IDLE_LAST  = UDPE_CNT_W'(IDLE_CYC - 1);
    localparam logic [UDPE_CNT_W-1:0] WAKE_LAST  = UDPE_CNT_W'(WAKE_CYC - 1);
    localparam logic [10:0] ISO_MAX = 11'(UDPE_ISO_MAX_BYTES);

    typedef struct packed {
        logic [7:0]                    ctrl;
        logic [7:0]                    cfg;
        logic [6:0]                    addr;
        logic [10:0]                   frame;
        logic [7:0]                    transfer_status;
        logic [7:0]                    irq_en;
        logic [7:0]                    err_en;
        logic [UDPE_EP_REGS-1:0][7:0]  ep;
        logic [31:0]                   prdata;
        logic                          pslverr;
        udpe_link_e                    link;
        logic [UDPE_CNT_W-1:0]         frame_cnt;
        logic [UDPE_CNT_W-1:0]         idle_cnt;
        logic [UDPE_CNT_W-1:0]         wake_cnt;
        udpe_result_s                  result;
        logic                          frame_tick;
    } udpe_state_s;

    udpe_state_s st_reg;
    udpe_state_s st_next;
    logic [7:0]  irq_flags, err_flags, irq_set, irq_clear, err_set;
    logic [7:0]  err_clear, ep_off, rd_byte, tok_ep;
    logic [2:0]  ep_idx;
    logic        irq_pending, enabled, full_speed, wr_done, rd_done;
    logic        ep_hit, addr_hit, tok_live, tok_ours, tok_iso, tok_ok;

    assign enabled    = st_reg.ctrl[UDPE_CTL_ENABLE];
    assign full_speed = st_reg.cfg[UDPE_CFG_FULLSPD];
    assign wr_done    = i_psel & i_penable & i_pwrite;
    assign rd_done    = i_psel & i_penable & ~i_pwrite;
    assign ep_off     = i_paddr - UDPE_OFS_EP0;
    assign ep_idx     = ep_off[4:2];
    assign ep_hit     = (i_paddr >= UDPE_OFS_EP0)
                      && (i_paddr <= UDPE_OFS_EP_LAST)
                      && (i_paddr[1:0] == 2'b00);

    // Register read mux
    always_comb begin
        rd_byte  = 8'h00;
        addr_hit = 1'b1;
        if (ep_hit) begin
            rd_byte = st_reg.ep[ep_idx];
        end else begin
            unique case (i_paddr)
                UDPE_OFS_CONTROL:  rd_byte = st_reg.ctrl;
                UDPE_OFS_CONFIG:   rd_byte = st_reg.cfg;
                UDPE_OFS_STATUS:   rd_byte = st_reg.transfer_status;
                UDPE_OFS_ADDRESS:  rd_byte = {1'b0, st_reg.addr};
                UDPE_OFS_FRAME_LO: rd_byte = st_reg.frame[7:0];
                UDPE_OFS_FRAME_HI: rd_byte = {5'h00, st_reg.frame[10:8]};
                UDPE_OFS_IRQ_FLAG: rd_byte = irq_flags;
                UDPE_OFS_IRQ_EN:   rd_byte = st_reg.irq_en;
                UDPE_OFS_ERR_FLAG: rd_byte = err_flags;
                UDPE_OFS_ERR_EN:   rd_byte = st_reg.err_en;
                default:           addr_hit = 1'b0;
            endcase
        end
    end

    // Token decode against address and endpoint table
    always_comb begin
        tok_live = i_token.valid & enabled;
        tok_ours = tok_live && (i_token.pid != UDPE_PID_SOF)
                 && (i_token.addr == st_reg.addr);
        tok_ep   = 8'h00;
        if (i_token.endp < 4'(UDPE_EP_REGS)) begin
            tok_ep = st_reg.ep[i_token.endp[2:0]];
        end
        if (i_token.endp == 4'h0) begin
            tok_ep[UDPE_EP_HSHK]   = 1'b1;
            tok_ep[UDPE_EP_CONDIS] = 1'b0;
            tok_ep[UDPE_EP_OUTEN]  = 1'b1;
            tok_ep[UDPE_EP_INEN]   = 1'b1;
        end
        tok_iso = ~tok_ep[UDPE_EP_HSHK];
        unique case (i_token.pid)
            UDPE_PID_IN:    tok_ok = tok_ep[UDPE_EP_INEN];
            UDPE_PID_OUT:   tok_ok = tok_ep[UDPE_EP_OUTEN];
            UDPE_PID_SETUP: tok_ok = tok_ep[UDPE_EP_OUTEN]
                                   & ~tok_ep[UDPE_EP_CONDIS];
            UDPE_PID_SOF:   tok_ok = 1'b0;
        endcase
        if (tok_iso && !full_speed) begin
            tok_ok = 1'b0;
        end
        if (tok_iso && (i_token.len > ISO_MAX)) begin
            tok_ok = 1'b0;
        end
    end

    // Event flag sources; read of a flag register clears what it returned
    always_comb begin
        irq_set = 8'h00;
        irq_set[UDPE_IRQ_SOF]   = tok_live && (i_token.pid == UDPE_PID_SOF);
        irq_set[UDPE_IRQ_STALL] = tok_ours && tok_ok
                                && tok_ep[UDPE_EP_STALL];
        irq_set[UDPE_IRQ_IDLE]  = enabled && (st_reg.link == UDPE_LS_ACTIVE)
                                && (st_reg.idle_cnt == IDLE_LAST);
        irq_set[UDPE_IRQ_TRN]   = enabled & i_xfer_done;
        irq_set[UDPE_IRQ_ACTV]  = enabled & i_bus_activity;
        irq_set[UDPE_IRQ_ERR]   = enabled
                                & (|(i_link_errors & st_reg.err_en));
        irq_set[UDPE_IRQ_RESET] = enabled & i_bus_reset;
        err_set   = enabled ? (i_link_errors & UDPE_ERR_WMASK) : 8'h00;
        irq_clear = (rd_done && i_paddr == UDPE_OFS_IRQ_FLAG)
                  ? st_reg.prdata[7:0] : 8'h00;
        err_clear = (rd_done && i_paddr == UDPE_OFS_ERR_FLAG)
                  ? st_reg.prdata[7:0] : 8'h00;
    end

    always_comb begin
        st_next            = st_reg;
        st_next.result     = '0;
        st_next.frame_tick = 1'b0;
        // APB: read data captured in setup, writes land at access
        if (i_psel && !i_penable) begin
            st_next.prdata  = {24'h000000, rd_byte};
            st_next.pslverr = ~addr_hit;
        end
        if (wr_done && addr_hit) begin
            if (ep_hit) begin
                st_next.ep[ep_idx] = i_pwdata[7:0] & UDPE_EP_WMASK;
            end else begin
                unique case (i_paddr)
                    UDPE_OFS_CONTROL:
                        st_next.ctrl = i_pwdata[7:0] & UDPE_CTL_WMASK;
                    UDPE_OFS_CONFIG:
                        st_next.cfg = i_pwdata[7:0] & UDPE_CFG_WMASK;
                    UDPE_OFS_ADDRESS:
                        st_next.addr = i_pwdata[6:0];
                    UDPE_OFS_IRQ_EN:
                        st_next.irq_en = i_pwdata[7:0] & UDPE_IRQ_WMASK;
                    UDPE_OFS_ERR_EN:
                        st_next.err_en = i_pwdata[7:0] & UDPE_ERR_WMASK;
                    default: ;
                endcase
            end
        end
        // Frame timer, realigned by every SOF
        if (!enabled) begin
            st_next.frame_cnt = '0;
        end else if (irq_set[UDPE_IRQ_SOF]) begin
            st_next.frame_cnt  = '0;
            st_next.frame_tick = 1'b1;
            st_next.frame      = i_token.frame;
        end else if (st_reg.frame_cnt == FRAME_LAST) begin
            st_next.frame_cnt  = '0;
            st_next.frame_tick = 1'b1;
        end else begin
            st_next.frame_cnt = st_reg.frame_cnt + 1'b1;
        end
        // Token answer, one cycle after the token
        if (tok_ours) begin
            st_next.result.valid     = 1'b1;
            st_next.result.accept    = tok_ok;
            st_next.result.stall     = tok_ok & tok_ep[UDPE_EP_STALL];
            st_next.result.handshake = tok_ok & ~tok_iso;
            st_next.result.setup     = tok_ok
                                     && (i_token.pid == UDPE_PID_SETUP);
            if (tok_ok) begin
                st_next.transfer_status = 8'h00;
                st_next.transfer_status[UDPE_STAT_EP_LSB +: 4] = i_token.endp;
                st_next.transfer_status[UDPE_STAT_DIR] =
                    (i_token.pid == UDPE_PID_IN);
            end
        end
        // Link power state
        unique case (st_reg.link)
            UDPE_LS_ACTIVE: begin
                if (irq_set[UDPE_IRQ_SOF] || !enabled) begin
                    st_next.idle_cnt = '0;
                end else if (st_reg.idle_cnt == IDLE_LAST) begin
                    st_next.idle_cnt = '0;
                    st_next.link     = UDPE_LS_SUSPENDED;
                end else begin
                    st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
                end
            end
            UDPE_LS_SUSPENDED: begin
                if (i_bus_activity) begin
                    st_next.link = UDPE_LS_ACTIVE;
                end else if (i_wake_request) begin
                    st_next.wake_cnt = '0;
                    st_next.link     = UDPE_LS_WAKING;
                end
            end
            UDPE_LS_WAKING: begin
                if (i_bus_activity) begin
                    st_next.link = UDPE_LS_ACTIVE;
                end else if (st_reg.ctrl[UDPE_CTL_RESUME]
                             || st_reg.wake_cnt == WAKE_LAST) begin
                    st_next.link = UDPE_LS_RESUMING;
                end else begin
                    st_next.wake_cnt = st_reg.wake_cnt + 1'b1;
                end
            end
            UDPE_LS_RESUMING: begin
                if (i_bus_activity) begin
                    st_next.link = UDPE_LS_ACTIVE;
                end
            end
        endcase
        if (!enabled) begin
            st_next.link = UDPE_LS_ACTIVE;
        end
        // Bus reset: unconfigured, default address, only endpoint 0 left
        if (enabled && i_bus_reset) begin
            st_next.addr     = UDPE_DEFAULT_ADDR;
            st_next.link     = UDPE_LS_ACTIVE;
            st_next.idle_cnt = '0;
            for (int i = 1; i < UDPE_EP_REGS; i++) begin
                st_next.ep[i] = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg       <= '0;
            st_reg.ep[0] <= UDPE_EP0_RESET;
            st_reg.link  <= UDPE_LS_ACTIVE;
        end else begin
            st_reg <= st_next;
        end
    end
    udpe_flag_bank u_irq_flags (
        .i_clock   (i_clock),
        .i_nrst    (i_nrst),
        .i_set     (irq_set),
        .i_clear   (irq_clear),
        .i_mask    (st_reg.irq_en),
        .o_flags   (irq_flags),
        .o_pending (irq_pending)
    );
    udpe_flag_bank u_err_flags (
        .i_clock   (i_clock),
        .i_nrst    (i_nrst),
        .i_set     (err_set),
        .i_clear   (err_clear),
        .i_mask    (st_reg.err_en),
        .o_flags   (err_flags),
        .o_pending ()
    );
    assign o_prdata        = st_reg.prdata;
    assign o_pready        = 1'b1;
    assign o_pslverr       = i_psel & i_penable & st_reg.pslverr;
    assign o_result        = st_reg.result;
    assign o_frame_tick    = st_reg.frame_tick;
    assign o_pullup_dp     = enabled & st_reg.cfg[UDPE_CFG_PULLUP]
                           & full_speed;
    assign o_pullup_dm     = enabled & st_reg.cfg[UDPE_CFG_PULLUP]
                           & ~full_speed;
    assign o_pin_detect_en = ~enabled;
    assign o_suspended     = (st_reg.link == UDPE_LS_SUSPENDED)
                           | st_reg.ctrl[UDPE_CTL_SUSPEND];
    assign o_resume_drive  = (st_reg.link == UDPE_LS_RESUMING);
    assign o_irq           = irq_pending;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    sequence s_sof_seen;
        i_token.valid && enabled && i_token.pid == UDPE_PID_SOF;
    endsequence
    sequence s_reset_seen;
        enabled && i_bus_reset;
    endsequence

    AST_FRAME_REALIGN: assert property (
        s_sof_seen |=> o_frame_tick && st_reg.frame_cnt == '0)
        else $error("frame timer not realigned by SOF");
    AST_FRAME_CAPTURE: assert property (
        s_sof_seen |=> st_reg.frame == $past(i_token.frame))
        else $error("SOF frame number not captured");
    AST_IDLE_SUSPEND: assert property (
        st_reg.link == UDPE_LS_ACTIVE && enabled
        && st_reg.idle_cnt == IDLE_LAST && !i_token.valid && !i_bus_reset
        |=> o_suspended && irq_flags[UDPE_IRQ_IDLE])
        else $error("no suspend after idle time");
    AST_WAKE_BOUND: assert property (
        st_reg.link == UDPE_LS_WAKING |-> st_reg.wake_cnt <= WAKE_LAST)
        else $error("wake-up signalling late");
    AST_WAKE_DRIVE: assert property (
        st_reg.link == UDPE_LS_WAKING && st_reg.wake_cnt == WAKE_LAST
        && !i_bus_activity && !i_bus_reset && enabled |=> o_resume_drive)
        else $error("resume not driven at wake deadline");
    AST_ADDR_RESET: assert property (
        s_reset_seen |=> st_reg.addr == UDPE_DEFAULT_ADDR
        && st_reg.ep[1] == 8'h00)
        else $error("bus reset left address set");
    AST_EP0_CONTROL: assert property (
        tok_ours && i_token.endp == 4'h0 && i_token.pid == UDPE_PID_SETUP
        |=> o_result.valid && o_result.accept && o_result.setup)
        else $error("endpoint 0 refused a setup");
    AST_EP_RANGE: assert property (
        tok_ours && i_token.endp >= 4'(UDPE_EP_REGS)
        |=> o_result.valid && !o_result.accept)
        else $error("unbacked endpoint accepted");
    AST_LS_NO_ISO: assert property (
        tok_ours && tok_iso && !full_speed |=> !o_result.accept)
        else $error("isochronous accepted at low speed");
    AST_ISO_NO_RETRY: assert property (
        tok_ours && tok_iso |=> !o_result.handshake)
        else $error("isochronous transfer handshaked");
    AST_PULLUP_SPEED: assert property (
        $rose(o_pullup_dp) |-> full_speed && !o_pullup_dm)
        else $error("pull-up on wrong line");
    AST_PIN_DETECT: assert property (
        wr_done && i_paddr == UDPE_OFS_CONTROL
        && i_pwdata[UDPE_CTL_ENABLE] |=> !o_pin_detect_en)
        else $error("pin detection left on after enable");

endmodule // udpe_engine

// ===== sim/udpe_host_model.sv
`timescale 1ns/1ps
module udpe_host_model
    import udpe_pkg::*;
(
    input  wire logic  i_clock,
    output udpe_token_s o_token,
    output logic       o_bus_reset,
    output logic       o_bus_activity
);

    initial begin
        o_token        = '0;
        o_bus_reset    = 1'b0;
        o_bus_activity = 1'b0;
    end

    // One token per two cycles; released fields toggle, never hold
    task automatic send(input udpe_pid_e p, input logic [6:0] a,
                        input logic [3:0] e, input logic [10:0] f,
                        input logic [10:0] l);
        @(posedge i_clock) o_token <= '{1'b1, p, a, e, f, l};
        @(posedge i_clock) o_token <= ~o_token;
    endtask

    // Reset ahead of address assignment
    task automatic bus_reset();
        @(posedge i_clock) o_bus_reset <= 1'b1;
        @(posedge i_clock) o_bus_reset <= 1'b0;
    endtask

    task automatic activity();
        @(posedge i_clock) o_bus_activity <= 1'b1;
        @(posedge i_clock) o_bus_activity <= 1'b0;
    endtask

endmodule // udpe_host_model

// ===== sim/test_udpe_engine.sv
`timescale 1ns/1ps
module test_udpe_engine
    import udpe_pkg::*;
;
    localparam int F = 100;
    localparam int I = 300;
    localparam int W = 1000;
    logic         i_clock, i_nrst, psel, pen, pwr, wake, err, stl;
    logic         pready, tick, dp, dm, pde, susp, rdrv, irq, brst, bact;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd, rs;
    udpe_token_s  tok;
    udpe_result_s res;
    logic [3:0]   q[$];
    logic [3:0]   e;
    int           miscompares, checks_done, n;

    udpe_engine #(.FRAME_CYC(F), .IDLE_CYC(I), .WAKE_CYC(W)) u_udpe_engine (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(err), .i_token(tok), .i_bus_reset(brst),
        .i_bus_activity(bact), .i_xfer_done(1'b0),
        .i_link_errors(8'h00), .i_wake_request(wake), .o_result(res),
        .o_frame_tick(tick), .o_pullup_dp(dp), .o_pullup_dm(dm),
        .o_pin_detect_en(pde), .o_suspended(susp),
        .o_resume_drive(rdrv), .o_irq(irq));

    udpe_host_model u_udpe_host_model (
        .i_clock(i_clock), .o_token(tok), .o_bus_reset(brst),
        .o_bus_activity(bact));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string s, input logic [31:0] v,
                       input logic [31:0] x);
        checks_done++;
        if (v !== x) begin
            miscompares++;
            $display("Error %s expected %h seen %h", s, x, v);
        end
    endtask

    task automatic wt(input int k);
        repeat (k) @(posedge i_clock);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_clock) begin
            psel <= 1'b1;
            pen <= 1'b0;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
        end
        @(posedge i_clock) pen <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("prdata", rd, x);
    endtask

    // x: want result, care handshake, accept, setup, handshake
    task automatic tk(input udpe_pid_e p, input logic [6:0] a,
                      input logic [3:0] ep, input logic [10:0] l,
                      input logic [4:0] x);
        if (x[4]) q.push_back(x[3:0]);
        u_udpe_host_model.send(p, a, ep, 11'h000, l);
        wt(2);
    endtask

    task automatic finish_test();
        chk("queue left", q.size(), 32'h0);
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge i_clock) begin
        if (res.valid === 1'b1) begin
            chk("pending", q.size() > 0, 32'h1);
            e = (q.size() > 0) ? q.pop_front() : 4'h0;
            chk("accept", res.accept, e[2]);
            chk("setup", res.setup, e[1]);
            if (e[3]) chk("handshake", res.handshake, e[0]);
            chk("stall", res.stall, e[2] & stl);
        end
    end

    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    initial begin
        {i_nrst, psel, pen, pwr, wake, stl, paddr, pwdata} = '0;
        rs = 32'h55;
        wt(4);
        i_nrst <= 1'b1;
        rdc(UDPE_OFS_EP0, {24'h0, UDPE_EP0_RESET});
        rdc(UDPE_OFS_ADDRESS, 32'h0);
        chk("detect", pde, 32'h1);
        rdc(8'h80, 32'h0);
        chk("slverr", err, 32'h1);
        $display("test reset done");
        apb(1'b1, UDPE_OFS_CONTROL, 32'h08);
        wt(2);
        chk("detect", pde, 32'h0);
        apb(1'b1, UDPE_OFS_CONFIG, 32'h10);
        wt(2);
        chk("pullups", {dp, dm}, 32'h1);
        apb(1'b1, UDPE_OFS_EP0 + 8'h04, 32'h06);
        tk(UDPE_PID_IN, 7'h00, 4'h1, 11'h00A, 5'h10);
        apb(1'b1, UDPE_OFS_CONFIG, 32'h14);
        wt(2);
        chk("pullups", {dp, dm}, 32'h2);
        tk(UDPE_PID_IN, 7'h00, 4'h1, 11'h3FF, 5'h1C);
        tk(UDPE_PID_OUT, 7'h00, 4'h1, 11'h400, 5'h10);
        tk(UDPE_PID_OUT, 7'h00, 4'h0, 11'h008, 5'h1D);
        tk(UDPE_PID_IN, 7'h00, 4'h0, 11'h008, 5'h1D);
        tk(UDPE_PID_SETUP, 7'h00, 4'h0, 11'h008, 5'h1F);
        tk(UDPE_PID_IN, 7'h00, 4'h8, 11'h008, 5'h10);
        apb(1'b1, UDPE_OFS_ADDRESS, 32'h05);
        tk(UDPE_PID_IN, 7'h00, 4'h0, 11'h008, 5'h00);
        tk(UDPE_PID_IN, 7'h05, 4'h0, 11'h008, 5'h1D);
        stl = 1'b1;
        apb(1'b1, UDPE_OFS_EP0, 32'h17);
        tk(UDPE_PID_IN, 7'h05, 4'h0, 11'h008, 5'h1D);
        stl = 1'b0;
        apb(1'b1, UDPE_OFS_EP0, {24'h0, UDPE_EP0_RESET});
        u_udpe_host_model.bus_reset();
        wt(2);
        rdc(UDPE_OFS_ADDRESS, 32'h0);
        tk(UDPE_PID_IN, 7'h00, 4'h0, 11'h008, 5'h1D);
        $display("test tokens done");
        rs = xs(rs);
        apb(1'b1, UDPE_OFS_IRQ_EN, 32'h40);
        u_udpe_host_model.send(UDPE_PID_SOF, 7'h00, 4'h0, rs[10:0], 11'h0);
        wt(2);
        chk("irq", irq, 32'h1);
        rdc(UDPE_OFS_FRAME_LO, {24'h0, rs[7:0]});
        rdc(UDPE_OFS_FRAME_HI, {29'h0, rs[10:8]});
        apb(1'b1, UDPE_OFS_IRQ_EN, 32'h00);
        wt(2);
        chk("irq masked", irq, 32'h0);
        apb(1'b1, UDPE_OFS_IRQ_EN, 32'h40);
        wt(2);
        chk("irq unmasked", irq, 32'h1);
        apb(1'b0, UDPE_OFS_IRQ_FLAG, 32'h0);
        chk("frame flag", rd[UDPE_IRQ_SOF], 32'h1);
        wt(2);
        chk("irq cleared", irq, 32'h0);
        $display("test interrupt done");
        u_udpe_host_model.send(UDPE_PID_SOF, 7'h00, 4'h0, 11'h001, 11'h0);
        wt(2);
        n = 1;
        while (tick !== 1'b1 && n < F + 9) begin
            wt(1);
            n++;
        end
        chk("frame gap", n, F);
        while (susp !== 1'b1 && n < I + 9) begin
            wt(1);
            n++;
        end
        chk("idle gap", n, I);
        wake <= 1'b1;
        wt(1);
        wake <= 1'b0;
        n = 0;
        while (rdrv !== 1'b1 && n < W + 9) begin
            wt(1);
            n++;
        end
        chk("wake delay", n <= W + 2, 32'h1);
        u_udpe_host_model.activity();
        wt(3);
        chk("awake", susp, 32'h0);
        $display("test power done");
        finish_test();
    end

endmodule // test_udpe_engine
